// file: common/awc_pkg.sv
// Constants shared by the advanced-mode interrupt and wake-up controller.
package awc_pkg;

    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PIN_COUNT = 4;
    localparam int unsigned GP_DEPTH = 8;
    localparam int unsigned GP_IDX_W = 3;

    // Data-memory addresses reached by the direct operand.
    localparam logic [6:0] ADDR_TIMER = 7'h01;
    localparam logic [6:0] ADDR_WAKE = 7'h20;
    localparam logic [6:0] ADDR_MASK = 7'h21;
    localparam logic [6:0] ADDR_FLAG = 7'h22;
    localparam logic [6:0] ADDR_GP_FIRST = 7'h28;
    localparam logic [6:0] ADDR_GP_LAST = 7'h2f;
    localparam logic [6:0] ADDR_TOP = 7'h3f;

    // Wake-up control register fields.
    localparam int unsigned WAKE_WDT_SW_BIT = 7;
    localparam int unsigned WAKE_MASTER_BIT = 6;
    localparam int unsigned WAKE_PIN0_SEL_BIT = 5;
    localparam int unsigned WAKE_PIN0_EN_BIT = 0;
    localparam logic [7:0] WAKE_IMPL = 8'hef;
    localparam logic [7:0] WAKE_RST = 8'h00;

    // Interrupt enable mask fields.
    localparam int unsigned MASK_GLOBAL_BIT = 7;
    localparam int unsigned MASK_EXT_BIT = 2;
    localparam int unsigned MASK_TMR_BIT = 0;
    localparam logic [7:0] MASK_IMPL = 8'h85;
    localparam logic [7:0] MASK_RST = 8'h00;

    // Interrupt pending flag fields.
    localparam int unsigned FLAG_EXT_BIT = 2;
    localparam int unsigned FLAG_TMR_BIT = 0;
    localparam logic [7:0] FLAG_IMPL = 8'h05;
    localparam logic [7:0] FLAG_RST = 8'h00;

    // Eight-bit timer.
    localparam logic [7:0] TIMER_RST = 8'h00;
    localparam logic [7:0] TIMER_MAX = 8'hff;
    localparam logic [7:0] TIMER_STEP = 8'h01;

    localparam logic [7:0] READ_ZERO = 8'h00;

    // Pin history after reset matches idle pulled-high pins, so no false edge follows.
    localparam logic [3:0] PIN_IDLE = 4'hf;

endpackage

// file: test/awc_irq_wake_ctrl_tb.sv
// Self-checking bench for the interrupt and wake-up controller.
`timescale 1ns/10ps
module awc_irq_wake_ctrl_tb;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [6:0] addr_i = 7'h00;
    logic [7:0] wr_data_i = 8'h00;
    logic wr_en_i = 1'b0, rd_en_i = 1'b0, sleep_i = 1'b0, cfg_en = 1'b0;
    logic tick = 1'b0, ack = 1'b0, reti = 1'b0;
    logic [3:0] press = 4'h0, port_a;
    logic [7:0] rd_data, v;
    logic hit, irq_req, in_svc, wake, wdt_run, p0_irq, p0_in;
    int num_errors = 0, n_compared = 0, wk_cnt = 0, m_tmr = 0, m_svc = 0;
    integer seed = 52;
    int m_reg[3] = '{0, 0, 0};
    logic [7:0] masks[3] = '{8'h84, 8'h01, 8'h81};
    int gp[8];

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    awc_pin_driver pins (.clk_i(clk_i), .press_i(press), .port_a_o(port_a));
    awc_irq_wake_ctrl uut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
        .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data), .hit_o(hit),
        .port_a_i(port_a), .sleep_i(sleep_i), .wdt_config_en_i(cfg_en), .timer_tick_i(tick),
        .irq_ack_i(ack), .reti_i(reti), .irq_req_o(irq_req), .in_service_o(in_svc),
        .wake_o(wake), .wdt_run_o(wdt_run), .pin0_is_irq_o(p0_irq), .pin0_irq_input_o(p0_in));

    always @(posedge clk_i) begin
        if (wake === 1'b1) wk_cnt++;
    end

    ////////////////////////////////////////////////////////////
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: byte %h, model %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: signal %b, model %b", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] mdl(input int a);
        if (a == 'h01) return m_tmr[7:0];
        if (a >= 'h20 && a <= 'h22) return m_reg[a - 'h20][7:0];
        if (a >= 'h28 && a <= 'h2f) return gp[a - 'h28][7:0];
        return 8'h00;
    endfunction

    function automatic logic exp_irq();
        return ((m_reg[2] & m_reg[1] & 5) != 0) && m_reg[1][7] && m_svc == 0 && !sleep_i;
    endfunction

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_en_i <= 1'b1;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
        if (a == 7'h01) m_tmr = d;
        if (a >= 7'h28 && a <= 7'h2f) gp[a - 7'h28] = d;
        if (a == awc_pkg::ADDR_WAKE) m_reg[0] = d & awc_pkg::WAKE_IMPL;
        if (a == awc_pkg::ADDR_MASK) m_reg[1] = d & awc_pkg::MASK_IMPL;
        if (a == awc_pkg::ADDR_FLAG) m_reg[2] = m_reg[2] & d;
        #1;
    endtask

    task automatic rd(input logic [6:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge clk_i);
        rd_en_i <= 1'b0;
        #1 v = rd_data;
    endtask

    // The release is left long enough that each press is a single clean edge.
    task automatic key(input int n);
        @(posedge clk_i) press[n] <= 1'b1;
        repeat (4) @(posedge clk_i);
        press[n] <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    task automatic conclude();
        $display("compared %0d, mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        conclude();
    end

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        for (int a = 'h20; a <= 'h30; a++) begin
            if (a < 'h23) begin
                rd(a[6:0]);
                chk_byte(v, 8'h00);
            end
            wr(a[6:0], 8'($random(seed)));
        end
        for (int a = 'h20; a <= 'h30; a++) begin
            rd(a[6:0]);
            chk_byte(v, mdl(a));
            chk_bit(hit, a < 'h23 || (a > 'h27 && a < 'h30));
        end
        // Back-to-back write then read of one byte, so the new value must already be stored.
        v = 8'($random(seed));
        gp[3] = v;
        @(posedge clk_i);
        addr_i <= 7'h2b;
        wr_data_i <= v;
        wr_en_i <= 1'b1;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
        rd_en_i <= 1'b1;
        @(posedge clk_i);
        rd_en_i <= 1'b0;
        #1 chk_byte(rd_data, mdl('h2b));
        rd(7'h40 | 7'($random(seed)));
        chk_byte(v, 8'h00);
        chk_bit(hit, 1'b0);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i) cfg_en <= i[0];
            wr(awc_pkg::ADDR_WAKE, {i[1], 7'h00});
            chk_bit(wdt_run, i[0] & i[1]);
        end
        $display("test watchdog done");
        @(posedge clk_i) sleep_i <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            for (int n = 1; n < 4; n++) begin
                wr(awc_pkg::ADDR_WAKE, {1'b0, m[0], 6'h00} | (8'h01 << n));
                wk_cnt = 0;
                key(n);
                key(n % 3 + 1);
                chk_byte(wk_cnt[7:0], {7'h00, m[0]});
            end
        end
        $display("test wake done");
        wr(awc_pkg::ADDR_MASK, 8'h84);
        wr(awc_pkg::ADDR_WAKE, 8'h60);
        wk_cnt = 0;
        key(0);
        rd(awc_pkg::ADDR_FLAG);
        chk_byte(v, mdl('h22));
        wr(awc_pkg::ADDR_WAKE, 8'h61);
        chk_bit(p0_irq, 1'b1);
        chk_bit(p0_in, 1'b1);
        key(0);
        m_reg[2] = m_reg[2] | 4;
        chk_byte(wk_cnt[7:0], 8'h01);
        chk_bit(irq_req, exp_irq());
        @(posedge clk_i) sleep_i <= 1'b0;
        #1 chk_bit(irq_req, exp_irq());
        @(posedge clk_i) ack <= 1'b1;
        @(posedge clk_i) ack <= 1'b0;
        m_reg[1] = m_reg[1] & 'h7f;
        m_svc = 1;
        #1 chk_bit(in_svc, 1'b1);
        wr(awc_pkg::ADDR_FLAG, 8'hff);
        rd(awc_pkg::ADDR_MASK);
        chk_byte(v, mdl('h21));
        rd(awc_pkg::ADDR_FLAG);
        chk_byte(v, mdl('h22));
        chk_bit(irq_req, exp_irq());
        @(posedge clk_i) reti <= 1'b1;
        @(posedge clk_i) reti <= 1'b0;
        m_reg[1] = m_reg[1] | 'h80;
        m_svc = 0;
        #1 chk_bit(irq_req, exp_irq());
        wr(awc_pkg::ADDR_FLAG, 8'h00);
        chk_bit(irq_req, exp_irq());
        $display("test pin interrupt done");
        wr(awc_pkg::ADDR_TIMER, 8'hfe);
        @(posedge clk_i) tick <= 1'b1;
        repeat (2) @(posedge clk_i);
        tick <= 1'b0;
        repeat (3) @(posedge clk_i);
        m_tmr = (m_tmr + 2) % 256;
        if (m_tmr < 2) m_reg[2] = m_reg[2] | 1;
        rd(awc_pkg::ADDR_TIMER);
        chk_byte(v, mdl('h01));
        rd(awc_pkg::ADDR_FLAG);
        chk_byte(v, mdl('h22));
        foreach (masks[k]) begin
            wr(awc_pkg::ADDR_MASK, masks[k]);
            chk_bit(irq_req, exp_irq());
        end
        $display("test timer done");
        @(posedge clk_i) sleep_i <= 1'b1;
        @(posedge clk_i) srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        sleep_i <= 1'b0;
        m_reg = '{0, 0, 0};
        rd(awc_pkg::ADDR_FLAG);
        chk_byte(v, 8'h00);
        chk_bit(irq_req, 1'b0);
        wr(awc_pkg::ADDR_MASK, 8'h85);
        chk_bit(irq_req, exp_irq());
        $display("test reset from sleep done");
        conclude();
    end
endmodule

// file: test/awc_pin_driver.sv
// Port A pin driver standing in for keys pulled high on the board.
`timescale 1ns/10ps
module awc_pin_driver (
    input wire logic clk_i,
    input wire logic [3:0] press_i,
    output logic [3:0] port_a_o
);
    // A released key returns to the pull-high level, so no stale low lingers.
    always_ff @(posedge clk_i) begin
        port_a_o <= ~press_i;
    end
endmodule

// file: verilog/awc_irq_wake_ctrl.sv
// Advanced-mode interrupt and wake-up controller with its directly addressed registers.
//
// Summary of operation
// RULE1 - Eight general-purpose bytes at 0x28 to 0x2F.
// RULE2 - Wake, mask, flag registers at 0x20-0x22.
// RULE3 - Seven-bit operand reaches 0x00-0x3F directly.
// RULE4 - Wake register clears on reset, software-writable.
// RULE5 - Watchdog runs when config and software enable.
// RULE6 - Wake bit 6 gates all pin wake-up.
// RULE7 - Wake bit 5 makes pin zero interrupt.
// RULE8 - Pins 3-1 falling edge wakes when enabled.
// RULE9 - Pin zero enable gates its wake and interrupt.
// RULE10 - All three pin-zero bits make interrupt input; a pin-zero edge sets flag bit 2 with wake bits 0 and 5 alone, bit 6 not needed.
// RULE11 - Interrupts wait while sleeping until pin wake.
// RULE12 - Reset out of sleep discards pending interrupts.
// RULE13 - Two sources, no nested interrupt service.
// RULE14 - Mask bit 7 globally enables all interrupts.
// RULE15 - Return from interrupt sets global enable.
// RULE16 - Mask bit 2 external, bit 0 timer.
// RULE17 - Pin-zero interrupt sets flag bit 2.
// RULE18 - Timer overflow sets flag bit 0.
// RULE19 - Hardware sets flags; writing zero clears.
// RULE20 - Timer is eight-bit, overflows 0xFF to 0x00.
// RULE21 - Request when flag, source and global enabled.
// RULE22 - Accepting an interrupt clears global enable.
`timescale 1ns/10ps
module awc_irq_wake_ctrl (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [6:0] addr_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_en_i,
    output logic [7:0] rd_data_o,
    output logic hit_o,
    input wire logic [3:0] port_a_i,
    input wire logic sleep_i,
    input wire logic wdt_config_en_i,
    input wire logic timer_tick_i,
    input wire logic irq_ack_i,
    input wire logic reti_i,
    output logic irq_req_o,
    output logic in_service_o,
    output logic wake_o,
    output logic wdt_run_o,
    output logic pin0_is_irq_o,
    output logic pin0_irq_input_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode and storage.

    logic [7:0] wake_q;
    logic [7:0] mask_q;
    logic [7:0] flag_q;
    logic [7:0] rd_data_q;
    logic [7:0] gp_mem [awc_pkg::GP_DEPTH];
    logic [3:0] port_a_q;
    logic [3:0] pin_fall;
    logic [3:0] wake_hit;
    logic [7:0] timer_count;
    logic timer_overflow;
    logic in_service_q;
    logic wake_pulse_q;
    logic in_range;
    logic sel_timer;
    logic sel_wake;
    logic sel_mask;
    logic sel_flag;
    logic sel_gp;
    logic [2:0] gp_idx;
    logic ext_set;
    logic tmr_set;
    logic src_pending;
    logic accept;

    // Bit 6 of the operand lies beyond the direct range and selects nothing.
    assign in_range = (addr_i <= awc_pkg::ADDR_TOP); // [RULE3]
    assign sel_timer = (addr_i == awc_pkg::ADDR_TIMER);
    assign sel_wake = (addr_i == awc_pkg::ADDR_WAKE); // [RULE2]
    assign sel_mask = (addr_i == awc_pkg::ADDR_MASK); // [RULE2]
    assign sel_flag = (addr_i == awc_pkg::ADDR_FLAG); // [RULE2]
    assign sel_gp = in_range && (addr_i >= awc_pkg::ADDR_GP_FIRST)
        && (addr_i <= awc_pkg::ADDR_GP_LAST); // [RULE1]
    assign gp_idx = addr_i[awc_pkg::GP_IDX_W-1:0];
    assign hit_o = sel_timer || sel_wake || sel_mask || sel_flag || sel_gp;

    always_ff @(posedge clk_i) begin
        if (wr_en_i && sel_gp) begin
            gp_mem[gp_idx] <= wr_data_i; // [RULE1]
        end
    end

    // Read data is registered; unmapped and unimplemented locations return zero.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rd_data_q <= awc_pkg::READ_ZERO;
        end else if (rd_en_i) begin
            if (sel_gp) begin
                rd_data_q <= gp_mem[gp_idx]; // [RULE1]
            end else if (sel_wake) begin
                rd_data_q <= wake_q & awc_pkg::WAKE_IMPL;
            end else if (sel_mask) begin
                rd_data_q <= mask_q & awc_pkg::MASK_IMPL;
            end else if (sel_flag) begin
                rd_data_q <= flag_q & awc_pkg::FLAG_IMPL;
            end else if (sel_timer) begin
                rd_data_q <= timer_count;
            end else begin
                rd_data_q <= awc_pkg::READ_ZERO; // [RULE3]
            end
        end
    end

    assign rd_data_o = rd_data_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Wake-up control register and pin roles.

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wake_q <= awc_pkg::WAKE_RST; // [RULE4]
        end else if (wr_en_i && sel_wake) begin
            wake_q <= wr_data_i & awc_pkg::WAKE_IMPL; // [RULE4] [RULE8]
        end
    end

    // The watchdog runs only when the configuration enable and the software bit are both set.
    assign wdt_run_o = wdt_config_en_i && wake_q[awc_pkg::WAKE_WDT_SW_BIT]; // [RULE5]
    assign pin0_is_irq_o = wake_q[awc_pkg::WAKE_PIN0_SEL_BIT]; // [RULE7]
    assign pin0_irq_input_o = wake_q[awc_pkg::WAKE_PIN0_EN_BIT]
        && wake_q[awc_pkg::WAKE_MASTER_BIT]
        && wake_q[awc_pkg::WAKE_PIN0_SEL_BIT]; // [RULE10]

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            port_a_q <= awc_pkg::PIN_IDLE;
        end else begin
            port_a_q <= port_a_i;
        end
    end

    // Per-pin enables share the pin number, so one loop covers pins 3 to 0.
    genvar pin;
    generate
        for (pin = 0; pin < awc_pkg::PIN_COUNT; pin++) begin : g_pin
            assign pin_fall[pin] = port_a_q[pin] && !port_a_i[pin];
            assign wake_hit[pin] = wake_q[awc_pkg::WAKE_MASTER_BIT] && wake_q[pin]
                && pin_fall[pin]; // [RULE6] [RULE8] [RULE9]
        end
    endgenerate

    // Only a pin edge wakes the core; resets leave through srst_i and clear all state except the general-purpose bytes and the pin history, which loads idle-high.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wake_pulse_q <= 1'b0;
        end else begin
            wake_pulse_q <= sleep_i && (|wake_hit); // [RULE6] [RULE8]
        end
    end

    assign wake_o = wake_pulse_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Timer and interrupt flags.

    awc_timer8 u_timer (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .tick_i(timer_tick_i),
        .wr_i(wr_en_i && sel_timer),
        .wr_data_i(wr_data_i),
        .count_o(timer_count),
        .overflow_o(timer_overflow)
    );

    assign ext_set = wake_q[awc_pkg::WAKE_PIN0_EN_BIT]
        && wake_q[awc_pkg::WAKE_PIN0_SEL_BIT] && pin_fall[0]; // [RULE9] [RULE17]
    assign tmr_set = timer_overflow; // [RULE18] [RULE20]

    // A write can only clear; a set arriving in the same cycle still wins.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flag_q <= awc_pkg::FLAG_RST; // [RULE12]
        end else begin
            if (wr_en_i && sel_flag) begin
                flag_q[awc_pkg::FLAG_EXT_BIT] <= ext_set
                    || (flag_q[awc_pkg::FLAG_EXT_BIT]
                    && wr_data_i[awc_pkg::FLAG_EXT_BIT]); // [RULE19]
                flag_q[awc_pkg::FLAG_TMR_BIT] <= tmr_set
                    || (flag_q[awc_pkg::FLAG_TMR_BIT]
                    && wr_data_i[awc_pkg::FLAG_TMR_BIT]); // [RULE19]
            end else begin
                flag_q[awc_pkg::FLAG_EXT_BIT] <= flag_q[awc_pkg::FLAG_EXT_BIT]
                    || ext_set; // [RULE17]
                flag_q[awc_pkg::FLAG_TMR_BIT] <= flag_q[awc_pkg::FLAG_TMR_BIT]
                    || tmr_set; // [RULE18]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mask register, request and service tracking.

    assign src_pending = (flag_q[awc_pkg::FLAG_EXT_BIT] && mask_q[awc_pkg::MASK_EXT_BIT])
        || (flag_q[awc_pkg::FLAG_TMR_BIT] && mask_q[awc_pkg::MASK_TMR_BIT]); // [RULE16]
    // Sleep holds the request back; the flag itself stays set for later service.
    assign irq_req_o = src_pending && mask_q[awc_pkg::MASK_GLOBAL_BIT]
        && !in_service_q && !sleep_i; // [RULE11] [RULE13] [RULE14] [RULE21]
    assign accept = irq_ack_i && irq_req_o;

    // Acceptance and return beat a software write to the global bit in the same cycle.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mask_q <= awc_pkg::MASK_RST;
        end else begin
            if (wr_en_i && sel_mask) begin
                mask_q <= wr_data_i & awc_pkg::MASK_IMPL; // [RULE16]
            end
            if (accept) begin
                mask_q[awc_pkg::MASK_GLOBAL_BIT] <= 1'b0; // [RULE22]
            end else if (reti_i) begin
                mask_q[awc_pkg::MASK_GLOBAL_BIT] <= 1'b1; // [RULE15]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            in_service_q <= 1'b0;
        end else if (accept) begin
            in_service_q <= 1'b1; // [RULE13]
        end else if (reti_i) begin
            in_service_q <= 1'b0;
        end
    end

    assign in_service_o = in_service_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    gp_store_a: assert property (wr_en_i && sel_gp ##1 rd_en_i && !wr_en_i // [RULE1]
        && addr_i == $past(addr_i) |=> rd_data_o == $past(wr_data_i, 2))
        else $error("general-purpose byte did not read back");
    wake_write_a: assert property (wr_en_i && sel_wake |=> // [RULE2] [RULE4]
        wake_q == ($past(wr_data_i) & awc_pkg::WAKE_IMPL))
        else $error("wake register write lost");
    unmapped_read_a: assert property (rd_en_i && !in_range |=> rd_data_o == 8'h00) // [RULE3]
        else $error("out-of-range read not zero");
    wdt_gate_a: assert property (!wdt_config_en_i |-> !wdt_run_o) // [RULE5]
        else $error("watchdog runs without configuration enable");
    wake_block_a: assert property (!wake_q[awc_pkg::WAKE_MASTER_BIT] |=> !wake_o) // [RULE6]
        else $error("wake while master enable is off");
    pin_wake_a: assert property (sleep_i && wake_q[awc_pkg::WAKE_MASTER_BIT] // [RULE8]
        && wake_q[1] && $fell(port_a_i[1]) |=> wake_o)
        else $error("pin one edge did not wake");
    pin0_role_a: assert property (pin0_irq_input_o |-> pin0_is_irq_o // [RULE7] [RULE10]
        && wake_q[awc_pkg::WAKE_PIN0_EN_BIT])
        else $error("pin zero role inconsistent");
    pin0_off_a: assert property (!wake_q[awc_pkg::WAKE_PIN0_EN_BIT] // [RULE9]
        && !flag_q[awc_pkg::FLAG_EXT_BIT] |=> !flag_q[awc_pkg::FLAG_EXT_BIT])
        else $error("external flag set with pin zero disabled");
    ext_flag_a: assert property (wake_q[awc_pkg::WAKE_PIN0_EN_BIT] // [RULE17]
        && wake_q[awc_pkg::WAKE_PIN0_SEL_BIT] && $fell(port_a_i[0])
        |=> flag_q[awc_pkg::FLAG_EXT_BIT])
        else $error("pin zero edge did not set external flag");
    timer_flag_a: assert property (timer_tick_i && !(wr_en_i && sel_timer) // [RULE18] [RULE20]
        && timer_count == 8'hff |=> timer_count == 8'h00 ##1
        flag_q[awc_pkg::FLAG_TMR_BIT])
        else $error("timer overflow did not set timer flag");
    flag_one_a: assert property (wr_en_i && sel_flag && !ext_set // [RULE19]
        && !flag_q[awc_pkg::FLAG_EXT_BIT] |=> !flag_q[awc_pkg::FLAG_EXT_BIT])
        else $error("writing one set a flag");
    sleep_hold_a: assert property (sleep_i |-> !irq_req_o) // [RULE11]
        else $error("request raised during sleep");
    no_nest_a: assert property (accept && !reti_i |=> !irq_req_o // [RULE13] [RULE22]
        && !mask_q[awc_pkg::MASK_GLOBAL_BIT])
        else $error("second interrupt possible during service");
    reti_gie_a: assert property (reti_i && !accept |=> // [RULE15]
        mask_q[awc_pkg::MASK_GLOBAL_BIT])
        else $error("return did not set global enable");
    req_cause_a: assert property (irq_req_o |-> // [RULE14] [RULE16] [RULE21]
        mask_q[awc_pkg::MASK_GLOBAL_BIT]
        && (mask_q & flag_q & awc_pkg::FLAG_IMPL) != 8'h00)
        else $error("request without enabled pending source");
    reset_discard_a: assert property (@(posedge clk_i) disable iff (1'b0) // [RULE12]
        srst_i |=> flag_q == 8'h00 && !in_service_q)
        else $error("reset did not discard pending interrupts");

    wake_seen_c: cover property (sleep_i ##1 wake_o);
    irq_taken_c: cover property (accept ##[1:20] reti_i);
    gp_round_c: cover property (wr_en_i && sel_gp ##1 rd_en_i && sel_gp);

endmodule

// file: verilog/awc_timer8.sv
// Eight-bit binary up-counter with a registered overflow pulse.
`timescale 1ns/10ps
module awc_timer8 (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic tick_i,
    input wire logic wr_i,
    input wire logic [7:0] wr_data_i,
    output logic [7:0] count_o,
    output logic overflow_o
);

    logic [7:0] count_q;
    logic overflow_q;

    // A software write wins over a tick in the same cycle, so a reload never races the count.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            count_q <= awc_pkg::TIMER_RST;
        end else if (wr_i) begin
            count_q <= wr_data_i;
        end else if (tick_i) begin
            count_q <= count_q + awc_pkg::TIMER_STEP;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            overflow_q <= 1'b0;
        end else begin
            overflow_q <= tick_i && !wr_i && (count_q == awc_pkg::TIMER_MAX);
        end
    end

    assign count_o = count_q;
    assign overflow_o = overflow_q;

endmodule
